// file: design/drt_refresh_ctrl.sv
/*
 DRAM bank type, refresh engine and burst EDO mode-program cycle.
 Assumes: registers reached on a plain strobe port with read data one cycle
 later; bank enables and 64-bit pairing come from the bank configuration
 logic; the access sequencer holds access_busy while it owns the strobes.
*/
`timescale 1ns/10ps

// Behaviour
// [RULE1] Per-bank 2-bit type: 00 standard, 01 EDO, 10 burst EDO, 11 reserved.
// [RULE2] Type register holds bank n type at bits 2n+1:2n, bank 7 on top.
// [RULE3] Scheme bit 0 gives CAS-before-RAS refresh, 1 gives RAS-only refresh.
// [RULE4] Refresh precharge field: 00=5, 01=4, 10=3, 11=2 clocks.
// [RULE5] Separate 2-bit field sets RAS pulse width of refresh cycles.
// [RULE6] Refresh interval 3.75/7.5/15/30/120 us; 101 stops refresh.
// [RULE7] Self-refresh enable puts memory in self-refresh during suspend.
// [RULE8] Stagger select 00 refreshes all banks together; 01 is reserved.
// [RULE9] Enable bit turns the burst EDO mode-program cycle on or off.
// [RULE10] Pair selector 00..11 chooses banks 0/1, 2/3, 4/5 or 6/7.
// [RULE11] Program cycle strobes CAS only on enabled, burst EDO, selected banks.
// [RULE12] Trigger runs one cycle; program cycle if enabled, else refresh.
// [RULE13] Program cycle drives address field on lines, write enable held low.
// [RULE14] Address line 0 is register bit 4, line 11 is bit 15.
// [RULE15] Software sets lines 11:1 to 00000010000; line 0 picks burst order.
// [RULE16] Trigger clears itself when its cycle completes.
module drt_refresh_ctrl #(
	parameter int unsigned LONG_PERIOD_CYC = drt_pkg::PER4_CYC
) (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        arst_n,
	input  wire logic                        clk_en,
	// Register port
	input  wire logic [drt_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [drt_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [drt_pkg::DATA_W-1:0]  reg_rdata,
	// System state
	input  wire logic [7:0]                  bank_enable,
	input  wire logic [3:0]                  bank_pair_wide,
	input  wire logic                        system_suspend,
	input  wire logic                        access_busy,
	// Memory strobes
	output logic      [7:0]                  ras_n,
	output logic      [3:0]                  column_strobe_group_a_n,
	output logic      [3:0]                  column_strobe_group_b_n,
	output logic      [11:0]                 memory_address_lines,
	output logic                             write_enable_n,
	// Status
	output logic                             refresh_busy,
	output logic                             self_refresh_active
);
	import drt_pkg::*;

	logic [15:0] type_reg;
	logic [15:0] rfsh_reg;
	logic [15:0] bmode_reg;
	logic [12:0] timer_reg;
	logic        pend_reg;
	logic [11:0] row_reg;
	drt_state_e  state_reg;
	drt_op_e     op_reg;
	logic        trig_op_reg;
	logic [2:0]  cnt_reg;
	logic [7:0]  ras_mask_reg;
	logic [7:0]  cas_mask_reg;

	// Type of bank n; an odd bank of a 64-bit pair follows its even partner
	function automatic drt_type_e bank_type(input logic [15:0] t,
		input logic [3:0] wide, input int n);
		int src;
		src = (wide[n/2] && (n % 2 == 1)) ? n - 1 : n;
		return drt_type_e'(t[2*src +: 2]); // [RULE1] [RULE2]
	endfunction

	function automatic logic bank_on(input logic [7:0] en,
		input logic [3:0] wide, input int n);
		return wide[n/2] ? en[n - (n % 2)] : en[n];
	endfunction

	function automatic logic [12:0] period_cyc(input logic [2:0] sel);
		case (sel)
			3'b000:  period_cyc = PER0_CYC;
			3'b001:  period_cyc = PER1_CYC;
			3'b010:  period_cyc = PER2_CYC;
			3'b011:  period_cyc = PER3_CYC;
			3'b100:  period_cyc = 13'(LONG_PERIOD_CYC);
			default: period_cyc = 13'h0000; // [RULE6]
		endcase
	endfunction

	logic [7:0]  active_banks;
	logic [7:0]  prog_banks;
	logic [2:0]  pair_sel;
	logic [12:0] period;
	logic [2:0]  pre_cyc;
	logic [2:0]  pw_cyc;
	logic        tick;
	logic        self_req;
	logic        trig_req;
	logic        prog_en;
	logic        trig_done;
	logic        start;
	logic        trig_write;

	assign pair_sel = {1'b0, bmode_reg[PAIR_LSB +: 2]};
	assign prog_en  = bmode_reg[EN_BIT]; // [RULE9]
	assign trig_req = bmode_reg[TRIG_BIT];
	assign self_req = system_suspend && rfsh_reg[SELF_BIT]; // [RULE7]
	assign period   = period_cyc(rfsh_reg[PER_LSB +: 3]);
	assign pre_cyc  = PRE_MAX_CYC - {1'b0, rfsh_reg[PRE_LSB +: 2]}; // [RULE4]
	assign pw_cyc   = PW_BASE_CYC + {1'b0, rfsh_reg[PW_LSB +: 2]}; // [RULE5]
	assign tick     = (period != 13'h0000) && (timer_reg >= period - 13'd1);
	assign start    = (state_reg == DRT_ST_IDLE) && !access_busy
		&& (self_req || trig_req || pend_reg);
	assign trig_done = clk_en && (state_reg == DRT_ST_PRECH)
		&& (cnt_reg == pre_cyc - 3'd1) && trig_op_reg;
	assign trig_write = reg_wr && (reg_addr == BMODE_OFS)
		&& reg_wdata[TRIG_BIT];

	// Stagger select 00 is the only defined mode: every bank at once
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bank
			assign active_banks[g] = bank_on(bank_enable, bank_pair_wide, g);
			assign prog_banks[g] = active_banks[g]
				&& (bank_type(type_reg, bank_pair_wide, g) == DRT_TYPE_BEDO)
				&& (3'(g / 2) == pair_sel); // [RULE10] [RULE11]
		end
	endgenerate

	// Register writes
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			type_reg <= TYPE_RST;
			rfsh_reg <= RFSH_RST;
		end
		else if (clk_en && reg_wr)
		begin
			if (reg_addr == TYPE_OFS)
				type_reg <= reg_wdata; // [RULE2]
			if (reg_addr == RFSH_OFS)
				rfsh_reg <= reg_wdata & RFSH_WMASK; // [RULE3] [RULE8]
		end
	end

	// Mode-program control; a new trigger write wins over completion
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			bmode_reg <= BMODE_RST;
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == BMODE_OFS)
				bmode_reg[15:4] <= reg_wdata[15:4]; // [RULE14] [RULE15]
			if (reg_wr && reg_addr == BMODE_OFS)
				bmode_reg[2:0] <= reg_wdata[2:0];
			if (trig_write)
				bmode_reg[TRIG_BIT] <= 1'b1; // [RULE12]
			else if (trig_done)
				bmode_reg[TRIG_BIT] <= 1'b0; // [RULE16]
		end
	end

	// Read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 16'h0000;
		else if (clk_en)
		begin
			if (!reg_rd)
				reg_rdata <= 16'h0000;
			else
			begin
				case (reg_addr)
					TYPE_OFS:  reg_rdata <= type_reg;
					RFSH_OFS:  reg_rdata <= rfsh_reg;
					BMODE_OFS: reg_rdata <= bmode_reg;
					STAT_OFS:  reg_rdata <= {13'h0000, pend_reg,
						self_refresh_active, refresh_busy};
					default:   reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Interval timer; a refresh owed but not yet run waits in pend_reg
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timer_reg <= 13'h0000;
			pend_reg  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (period == 13'h0000 || tick)
				timer_reg <= 13'h0000; // [RULE6]
			else
				timer_reg <= timer_reg + 13'd1;
			pend_reg <= tick || (pend_reg && !(start && !self_req
				&& !trig_req));
		end
	end

	// Refresh and mode-program sequencer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg               <= DRT_ST_IDLE;
			op_reg                  <= DRT_OP_CBR;
			trig_op_reg             <= 1'b0;
			cnt_reg                 <= 3'd0;
			ras_mask_reg            <= 8'h00;
			cas_mask_reg            <= 8'h00;
			row_reg                 <= 12'h000;
			ras_n                   <= 8'hff;
			column_strobe_group_a_n <= 4'hf;
			column_strobe_group_b_n <= 4'hf;
			memory_address_lines    <= 12'h000;
			write_enable_n          <= 1'b1;
			refresh_busy            <= 1'b0;
			self_refresh_active     <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state_reg)
				DRT_ST_IDLE:
				begin
					cnt_reg <= 3'd0;
					if (start)
					begin
						refresh_busy <= 1'b1;
						trig_op_reg  <= !self_req && trig_req;
						if (self_req)
						begin
							op_reg       <= DRT_OP_SELF;
							ras_mask_reg <= active_banks;
							cas_mask_reg <= 8'hff;
							column_strobe_group_a_n <= 4'h0;
							column_strobe_group_b_n <= 4'h0;
							state_reg    <= DRT_ST_LEAD;
						end
						else if (trig_req && prog_en)
						begin
							op_reg       <= DRT_OP_PROG;
							ras_mask_reg <= prog_banks;
							cas_mask_reg <= prog_banks; // [RULE11]
							column_strobe_group_a_n <=
								{4{!prog_banks[{pair_sel[1:0], 1'b0}]}};
							column_strobe_group_b_n <=
								{4{!prog_banks[{pair_sel[1:0], 1'b1}]}};
							memory_address_lines <=
								bmode_reg[MA_LSB +: 12]; // [RULE13] [RULE14]
							write_enable_n <= 1'b0; // [RULE13]
							state_reg    <= DRT_ST_LEAD;
						end
						else if (rfsh_reg[SCHEME_BIT])
						begin
							op_reg       <= DRT_OP_RAS; // [RULE3]
							ras_mask_reg <= active_banks;
							cas_mask_reg <= 8'h00;
							memory_address_lines <= row_reg;
							row_reg      <= row_reg + 12'd1;
							ras_n        <= ~active_banks;
							state_reg    <= DRT_ST_PULSE;
						end
						else
						begin
							op_reg       <= DRT_OP_CBR; // [RULE3] [RULE12]
							ras_mask_reg <= active_banks;
							cas_mask_reg <= 8'hff;
							column_strobe_group_a_n <= 4'h0;
							column_strobe_group_b_n <= 4'h0;
							state_reg    <= DRT_ST_LEAD;
						end
					end
				end
				DRT_ST_LEAD:
				begin
					// CAS leads RAS so the parts see CAS-before-RAS
					if (cnt_reg == LEAD_CYC - 3'd1)
					begin
						cnt_reg <= 3'd0;
						ras_n   <= ~ras_mask_reg;
						if (op_reg == DRT_OP_SELF)
						begin
							self_refresh_active <= 1'b1; // [RULE7]
							state_reg <= DRT_ST_SELF;
						end
						else
							state_reg <= DRT_ST_PULSE;
					end
					else
						cnt_reg <= cnt_reg + 3'd1;
				end
				DRT_ST_PULSE:
				begin
					if (cnt_reg == pw_cyc - 3'd1)
					begin
						cnt_reg <= 3'd0; // [RULE5]
						ras_n   <= 8'hff;
						column_strobe_group_a_n <= 4'hf;
						column_strobe_group_b_n <= 4'hf;
						write_enable_n <= 1'b1;
						state_reg <= DRT_ST_PRECH;
					end
					else
						cnt_reg <= cnt_reg + 3'd1;
				end
				DRT_ST_SELF:
				begin
					// Held until suspend ends or self-refresh enable clears; the parts refresh themselves
					if (!self_req)
					begin
						self_refresh_active <= 1'b0;
						ras_n   <= 8'hff;
						column_strobe_group_a_n <= 4'hf;
						column_strobe_group_b_n <= 4'hf;
						cnt_reg <= 3'd0;
						state_reg <= DRT_ST_PRECH;
					end
				end
				DRT_ST_PRECH:
				begin
					if (cnt_reg == pre_cyc - 3'd1)
					begin
						cnt_reg      <= 3'd0; // [RULE4]
						refresh_busy <= 1'b0;
						trig_op_reg  <= 1'b0; // [RULE16]
						state_reg    <= DRT_ST_IDLE;
					end
					else
						cnt_reg <= cnt_reg + 3'd1;
				end
				default:
				begin
					state_reg <= DRT_ST_IDLE;
					ras_n     <= 8'hff;
				end
			endcase
		end
	end

endmodule // drt_refresh_ctrl

// file: design/drt_pkg.sv
/*
 Constants for the DRAM type, refresh and mode-program configuration block:
 register offsets, field positions, reset values, encodings and timing.
 Assumes a 40 MHz CPU bus clock drives the block.
*/
package drt_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;

	// Register offsets as seen on the plain register port
	localparam logic [11:0] TYPE_OFS  = 12'h210;
	localparam logic [11:0] RFSH_OFS  = 12'h211;
	localparam logic [11:0] BMODE_OFS = 12'h212;
	localparam logic [11:0] STAT_OFS  = 12'h213;

	// Reset values
	localparam logic [15:0] TYPE_RST  = 16'h0000;
	localparam logic [15:0] RFSH_RST  = 16'h0040;
	localparam logic [15:0] BMODE_RST = 16'h0210;

	// Writable bits; reserved bits read as zero
	localparam logic [15:0] RFSH_WMASK  = 16'h34ff;
	localparam logic [15:0] BMODE_WMASK = 16'hfff7;

	// Refresh control fields
	localparam int SCHEME_BIT = 0;
	localparam int PRE_LSB    = 1;
	localparam int PW_LSB     = 3;
	localparam int PER_LSB    = 5;
	localparam int SELF_BIT   = 10;
	localparam int STAG_LSB   = 12;

	// Mode-program control fields
	localparam int EN_BIT   = 0;
	localparam int PAIR_LSB = 1;
	localparam int TRIG_BIT = 3;
	localparam int MA_LSB   = 4;

	// Status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SELF_BIT = 1;
	localparam int STAT_PEND_BIT = 2;

	typedef enum logic [1:0] {
		DRT_TYPE_STD  = 2'b00,
		DRT_TYPE_EDO  = 2'b01,
		DRT_TYPE_BEDO = 2'b10,
		DRT_TYPE_RSV  = 2'b11
	} drt_type_e;

	typedef enum logic [1:0] {
		DRT_OP_CBR  = 2'b00,
		DRT_OP_RAS  = 2'b01,
		DRT_OP_PROG = 2'b10,
		DRT_OP_SELF = 2'b11
	} drt_op_e;

	typedef enum logic [2:0] {
		DRT_ST_IDLE  = 3'b000,
		DRT_ST_LEAD  = 3'b001,
		DRT_ST_PULSE = 3'b010,
		DRT_ST_SELF  = 3'b011,
		DRT_ST_PRECH = 3'b100
	} drt_state_e;

	localparam logic [2:0] PER_STOPPED = 3'b101;

	// Refresh intervals in ns and their cycle counts
	localparam int CLK_MHZ = 40;
	localparam int PER0_NS = 3750;
	localparam int PER1_NS = 7500;
	localparam int PER2_NS = 15000;
	localparam int PER3_NS = 30000;
	localparam int PER4_NS = 120000;
	localparam logic [12:0] PER0_CYC = 13'(PER0_NS * CLK_MHZ / 1000);
	localparam logic [12:0] PER1_CYC = 13'(PER1_NS * CLK_MHZ / 1000);
	localparam logic [12:0] PER2_CYC = 13'(PER2_NS * CLK_MHZ / 1000);
	localparam logic [12:0] PER3_CYC = 13'(PER3_NS * CLK_MHZ / 1000);
	localparam int          PER4_CYC = PER4_NS * CLK_MHZ / 1000;

	// Refresh strobe timing in clocks
	localparam logic [2:0] PRE_MAX_CYC = 3'd5;
	localparam logic [2:0] PW_BASE_CYC = 3'd4;
	localparam logic [2:0] LEAD_CYC    = 3'd1;
endpackage

// file: verification/drt_refresh_ctrl_properties.sv
/*
 Port-level properties of the refresh and mode-program block.
 Assumes clk_en is held high and the access sequencer stays idle.
*/
`timescale 1ns/10ps
module drt_refresh_ctrl_properties (
	// Clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// Register port and system suspend
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        system_suspend,
	// Memory strobes and status
	input wire logic [7:0]  ras_n,
	input wire logic [3:0]  column_strobe_group_a_n,
	input wire logic [3:0]  column_strobe_group_b_n,
	input wire logic        write_enable_n,
	input wire logic        refresh_busy,
	input wire logic        self_refresh_active
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire logic cas_low = (column_strobe_group_a_n != 4'hf) ||
		(column_strobe_group_b_n != 4'hf);
	wire logic ras_low = ras_n != 8'hff;

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read slot");
	property p_cas_lead;
		$rose(ras_low) && cas_low |-> $past(cas_low);
	endproperty
	a_cas_lead: assert property (p_cas_lead)
		else $error("column strobe did not lead row strobe");
	property p_pulse_min;
		$rose(ras_low) && cas_low |=> ras_low [*3];
	endproperty
	a_pulse_min: assert property (p_pulse_min)
		else $error("refresh row pulse shorter than four clocks");
	property p_pre_min;
		$fell(refresh_busy) |-> $past(!ras_low) && $past(!ras_low, 2);
	endproperty
	a_pre_min: assert property (p_pre_min)
		else $error("precharge shorter than two clocks");
	property p_idle;
		!refresh_busy |-> !ras_low && !cas_low && write_enable_n;
	endproperty
	a_idle: assert property (p_idle)
		else $error("strobe active while idle");
	property p_we;
		!write_enable_n |-> refresh_busy && !self_refresh_active;
	endproperty
	a_we: assert property (p_we)
		else $error("write enable outside program cycle");
	property p_self_busy;
		self_refresh_active |-> refresh_busy;
	endproperty
	a_self_busy: assert property (p_self_busy)
		else $error("self-refresh without busy");
	property p_self_cause;
		$rose(self_refresh_active) |-> system_suspend;
	endproperty
	a_self_cause: assert property (p_self_cause)
		else $error("self-refresh entered outside suspend");
	property p_busy_bound;
		$rose(refresh_busy) && !system_suspend |-> ##[1:20] !refresh_busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound)
		else $error("refresh sequence did not end");
endmodule // drt_refresh_ctrl_properties

bind drt_refresh_ctrl drt_refresh_ctrl_properties u_props (
	.clock(clock), .arst_n(arst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .system_suspend(system_suspend),
	.ras_n(ras_n), .column_strobe_group_a_n(column_strobe_group_a_n),
	.column_strobe_group_b_n(column_strobe_group_b_n),
	.write_enable_n(write_enable_n), .refresh_busy(refresh_busy),
	.self_refresh_active(self_refresh_active));

// file: verification/drt_dram_model.sv
/*
 Passive DRAM bank model: decodes refresh and mode-program cycles.
 Assumes strobes are registered on the rising clock edge.
*/
`timescale 1ns/10ps
module drt_dram_model (
	// Memory side
	input wire logic        clock,
	input wire logic [7:0]  ras_n,
	input wire logic [3:0]  cas_a_n,
	input wire logic [3:0]  cas_b_n,
	input wire logic [11:0] ma,
	input wire logic        we_n,
	// Observations
	output int              cbr_cnt,
	output int              ras_only_cnt,
	output int              prog_cnt,
	output int              last_width,
	output logic [11:0]     prog_ma,
	output logic [15:0]     prog_strb
);
	logic [7:0] ras_q = 8'hff;
	int         w = 0;
	initial
	begin
		cbr_cnt = 0;
		ras_only_cnt = 0;
		prog_cnt = 0;
	end
	always @(posedge clock)
	begin
		if (ras_n != 8'hff && ras_q == 8'hff)
		begin
			if (cas_a_n == 4'hf && cas_b_n == 4'hf)
				ras_only_cnt++;
			else if (!we_n)
			begin
				// Mode register latched at row fall, as real parts do
				prog_cnt++;
				prog_ma <= ma;
				prog_strb <= {cas_a_n, cas_b_n, ras_n};
			end
			else
				cbr_cnt++;
		end
		w <= (ras_n != 8'hff) ? w + 1 : 0;
		if (ras_n == 8'hff && ras_q != 8'hff)
			last_width <= w;
		ras_q <= ras_n;
	end
endmodule // drt_dram_model

// file: verification/drt_refresh_ctrl_tb_top.sv
/*
 Self-checking bench for the refresh and mode-program block.
 Assumes the package constants; the long period is shortened to 40.
*/
`timescale 1ns/10ps
module drt_refresh_ctrl_tb_top;
	import drt_pkg::*;
	logic        clock = 0;
	logic        arst_n = 0;
	logic [11:0] reg_addr = 12'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic        system_suspend = 0;
	logic [7:0]  bank_enable = 8'hff;
	logic [15:0] reg_rdata;
	logic [7:0]  ras_n;
	logic [3:0]  cas_a_n;
	logic [3:0]  cas_b_n;
	logic [11:0] ma;
	logic        we_n;
	logic        busy;
	logic        self_on;
	int          err_total = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          cbr_cnt, ras_only_cnt, prog_cnt, last_width;
	logic [11:0] prog_ma;
	logic [15:0] prog_strb;

	always #12.5 clock = ~clock;

	drt_refresh_ctrl #(.LONG_PERIOD_CYC(40)) u_dut (
		.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bank_enable(bank_enable), .bank_pair_wide(4'h0),
		.system_suspend(system_suspend), .access_busy(1'b0),
		.ras_n(ras_n), .column_strobe_group_a_n(cas_a_n),
		.column_strobe_group_b_n(cas_b_n), .memory_address_lines(ma),
		.write_enable_n(we_n), .refresh_busy(busy),
		.self_refresh_active(self_on));
	drt_dram_model u_dram (
		.clock(clock), .ras_n(ras_n), .cas_a_n(cas_a_n),
		.cas_b_n(cas_b_n), .ma(ma), .we_n(we_n), .cbr_cnt(cbr_cnt),
		.ras_only_cnt(ras_only_cnt), .prog_cnt(prog_cnt),
		.last_width(last_width), .prog_ma(prog_ma),
		.prog_strb(prog_strb));

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask
	// Triggers one cycle and returns how many clocks busy stood high
	task automatic trig(input logic [15:0] v, output int n);
		n = 0;
		wr(BMODE_OFS, v);
		for (int k = 0; k < 60; k++)
		begin
			@(negedge clock);
			if (busy === 1'b1)
				n++;
			else if (n > 0)
				break;
		end
	endtask
	task automatic prog(input logic [15:0] ty, input logic [7:0] en,
		input logic [15:0] v, input logic [11:0] ema,
		input logic [15:0] estrb);
		int n;
		int p;
		p = prog_cnt;
		bank_enable <= en;
		wr(TYPE_OFS, ty);
		trig(v, n);
		chk(16'(prog_cnt - p), 16'd1);
		chk({4'h0, prog_ma}, {4'h0, ema});
		chk(prog_strb, estrb);
	endtask

	task automatic t_regs();
		rd(TYPE_OFS, 16'h0000);
		rd(RFSH_OFS, 16'h0040);
		rd(BMODE_OFS, 16'h0210);
		rd(12'h2ff, 16'h0000);
		wr(RFSH_OFS, 16'hffff);
		rd(RFSH_OFS, 16'h34ff);
		wr(RFSH_OFS, 16'h00a0);
		wr(TYPE_OFS, 16'ha5c3);
		wr(12'h2ff, 16'h1234);
		rd(TYPE_OFS, 16'ha5c3);
	endtask
	task automatic t_refresh();
		int n;
		int p;
		p = prog_cnt;
		trig(16'h0208, n);
		chk(16'(n), 16'd10);
		chk(16'(last_width), 16'd4);
		chk(16'(prog_cnt - p), 16'd0);
		rd(BMODE_OFS, 16'h0200);
		wr(RFSH_OFS, 16'h00ba);
		trig(16'h0208, n);
		chk(16'(n), 16'd12);
		chk(16'(last_width), 16'd7);
	endtask
	task automatic t_scheme();
		int n;
		int c;
		c = ras_only_cnt;
		wr(RFSH_OFS, 16'h00a1);
		trig(16'h0208, n);
		chk(16'(ras_only_cnt - c), 16'd1);
	endtask
	task automatic t_period();
		int c;
		c = cbr_cnt;
		wr(RFSH_OFS, 16'h0080);
		repeat (190) @(negedge clock);
		// Timer phase is unknown, so four or five ticks both pass
		chk(16'((cbr_cnt - c) / 2), 16'd2);
		wr(RFSH_OFS, 16'h00a0);
		repeat (20) @(negedge clock);
		c = cbr_cnt;
		repeat (100) @(negedge clock);
		chk(16'(cbr_cnt - c), 16'd0);
	endtask
	task automatic t_self();
		system_suspend <= 1'b1;
		repeat (10) @(negedge clock);
		chk({15'h0, self_on}, 16'h0000);
		wr(RFSH_OFS, 16'h04a0);
		repeat (10) @(negedge clock);
		chk({15'h0, self_on}, 16'h0001);
		chk({8'h00, ras_n}, 16'h0000);
		system_suspend <= 1'b0;
		repeat (20) @(negedge clock);
		chk({15'h0, self_on, busy}, 16'h0000);
	endtask

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			finish_test();
		end
	end

	initial
	begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		t_regs();
		t_refresh();
		prog(16'h00a0, 8'h04, 16'h021b, 12'h021, 16'h0ffb);
		prog(16'h90a0, 8'hc4, 16'h020f, 12'h020, 16'hf07f);
		bank_enable <= 8'hff;
		t_scheme();
		t_period();
		t_self();
		finish_test();
	end
endmodule // drt_refresh_ctrl_tb_top
